// ==== src/ibef_error_flags.sv ====
// Board error flag block: collects watchdog, bus, cyclic monitor, data,
// host, load and operation cycle faults into a read-only error word.
// Assumes all condition inputs come from logic on the same clock, and
// that the operation cycle strobe is a one-cycle pulse.
//
// What this block does
// - Bits 00 to 12 of the error word hold the error details; this block holds bits 10 to 12 at zero.
// - A flag reads 1 for an error present, 0 for normal.
// - Bit 00 sets when the watchdog finds the controller faulty.
// - Bit 01 sets on a fault of the internal bus to the host.
// - Cyclic monitor error when the token misses the monitor time.
// - Integrated process host variant reports it on bit 02.
// - Board and loop host variants report it on bit 05.
// - Bit 03 sets when the cold start data check finds corruption.
// - Bit 03 also sets when all block databases fail in duplex.
// - Bit 04 sets when mounted in an unsupported host.
// - Bits 06 and 07 are unused and read zero.
// - Bit 08 sets after three cycles running above 80 percent load.
// - Bit 09 sets in duplex on process host when host cycle too long.
// - Every detected error is recorded in the host-readable word.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module ibef_error_flags
    import ibef_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,

    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,

    // Fault conditions from the controller
    input  wire logic        watchdog_fault,
    input  wire logic        bus_fault,
    input  wire logic        token_sent,
    input  wire logic        token_returned,
    input  wire logic        cold_check_fail,
    input  wire logic        all_db_fail,
    input  wire logic        host_unsupported,

    // Operation cycle evaluation
    input  wire logic        op_cycle_tick,
    input  wire logic [6:0]  loop_controller_load,
    input  wire logic [15:0] host_cycle_time,
    input  wire logic [15:0] min_op_cycle,

    // Results
    output logic      [15:0] board_error_information_word,
    output logic             fatal_error,
    output logic             irq
);

    // All state lives in one record: the bus answer, the error word and
    // its status copy, the control registers and the two small timers.
    // Every top-level output is a field of it or, for waitrequest, the inverse of ack, so each comes from a flop.
    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
        logic [15:0] err;
        logic [15:0] status;
        logic [15:0] mask;
        logic [3:0]  config_bits;
        logic [23:0] mon_time;
        logic [23:0] mon_count;
        logic        mon_busy;
        logic [1:0]  load_run;
        logic        fatal;
        logic        irq;
    } ibef_state_type;

    // Reset leaves the word clean, the mask closed and the monitor
    // time at its default; the monitor itself stays off until config enables it.
    localparam ibef_state_type IBEF_RST_STATE = '{
        rdata:       32'h0000_0000,
        ack:         1'b0,
        err:         16'h0000,
        status:      16'h0000,
        mask:        IBEF_RST_MASK,
        config_bits: IBEF_RST_CONFIG,
        mon_time:    IBEF_RST_MONTIM,
        mon_count:   24'h000000,
        mon_busy:    1'b0,
        load_run:    2'h0,
        fatal:       1'b0,
        irq:         1'b0
    };

    // Fatal flags per the error word classes
    // Bits 00, 01, 02, 03 and 05 stop the controller; the rest only warn
    localparam logic [15:0] IBEF_FATAL_MASK = 16'h002F;

    ibef_state_type   state;
    ibef_state_type   next_state;
    ibef_variant_type variant;
    logic             duplex;
    logic             mon_en;
    logic             bus_go;
    logic             bus_done;
    logic             rd_clear;
    logic             cyc_timeout;
    logic             load_high;
    logic             opcyc_long;
    logic [18:0]      host_scaled;
    logic [15:0]      new_err;
    logic [15:0]      rise;
    logic [31:0]      wmask;
    logic [31:0]      reg_mux;

    // Config fields; an unused variant code of 3 acts as a board variant
    // for the cyclic monitor, since only code 1 moves the flag to bit 02.
    assign variant = ibef_variant_type'(
        state.config_bits[IBEF_CFG_VARIANT_LSB +: 2]);
    assign duplex  = state.config_bits[IBEF_CFG_DUPLEX];
    assign mon_en  = state.config_bits[IBEF_CFG_MON_EN];

    // One wait state: the request is seen, then answered for one cycle
    assign bus_go   = (read || write) && !state.ack;
    assign bus_done = (read || write) && state.ack;

    // A status read clears only what it has reported to the host
    assign rd_clear = bus_done && read && (address == IBEF_OFS_STATUS);

    // Byte lanes widen to a bit mask so partial writes keep other lanes
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        assign wmask[lane*8 +: 8] = {8{byteenable[lane]}};
    end

    // Timeout only while a token is out and has not come back
    // A return in the very cycle the count reaches the limit still wins,
    // so a token that is just in time never raises a fatal flag.
    assign cyc_timeout = mon_en && state.mon_busy && !token_returned
                         && (state.mon_count >= state.mon_time);

    assign load_high = loop_controller_load > IBEF_LOAD_LIMIT_PCT;

    // Widened product: a full-scale host cycle times five cannot overflow
    assign host_scaled = 19'(host_cycle_time) * 19'(IBEF_OPCYC_FACTOR);
    assign opcyc_long  = host_scaled > 19'(min_op_cycle);

    // Next state in one pass. Order matters only at the end: the error
    // word is settled first, then its rising bits feed the status copy,
    // and the interrupt is taken from the status and mask as they will
    // stand after this edge, so irq moves on the same edge as status.
    // The bus answers every access after one wait state: the request is
    // seen at one edge, read data is latched there, and the next edge
    // completes it. Side effects of the bus (writes, the status clear)
    // belong to that completing edge only, so a held request never
    // acts twice.
    always_comb begin
        next_state = state;
        new_err    = state.err;

        // Cyclic monitor timer runs from token hand-out to return
        if (token_sent) begin
            next_state.mon_busy  = 1'b1;
            next_state.mon_count = 24'h000000;
        end else if (token_returned || cyc_timeout) begin
            next_state.mon_busy  = 1'b0;
            next_state.mon_count = 24'h000000;
        end else if (state.mon_busy) begin
            next_state.mon_count = state.mon_count + 24'h000001;
        end

        // Fatal faults latch until reset so the cause is kept
        if (watchdog_fault) begin
            new_err[IBEF_BIT_WDT] = 1'b1;
        end
        if (bus_fault) begin
            new_err[IBEF_BIT_BUS] = 1'b1;
        end
        if (cyc_timeout) begin
            if (variant == IBEF_VAR_PROCESS_HOST) begin
                new_err[IBEF_BIT_CYC_PROC] = 1'b1;
            end else begin
                new_err[IBEF_BIT_CYC_BRD] = 1'b1;
            end
        end
        if (cold_check_fail) begin
            new_err[IBEF_BIT_DATA] = 1'b1;
        end
        if (all_db_fail && duplex) begin
            new_err[IBEF_BIT_DATA] = 1'b1;
        end

        // Host support follows its condition
        new_err[IBEF_BIT_HOST] = host_unsupported;


        // Load and cycle flags are judged once per operation cycle
        // The run counter saturates at three so a long overload keeps
        // the flag up without wrapping back to a quiet value.
        if (op_cycle_tick) begin
            if (!load_high) begin
                next_state.load_run = 2'h0;
            end else if (state.load_run != IBEF_LOAD_RUN) begin
                next_state.load_run = state.load_run + 2'h1;
            end
            new_err[IBEF_BIT_LOAD] = load_high
                && (state.load_run >= IBEF_LOAD_RUN - 2'h1);
            new_err[IBEF_BIT_OPCYC] = opcyc_long && duplex
                && (variant == IBEF_VAR_PROCESS_HOST);
        end

        // Unused and out-of-scope bits are held at zero
        new_err         = new_err & IBEF_USED_MASK;
        next_state.err  = new_err;
        next_state.fatal = |(new_err & IBEF_FATAL_MASK);

        rise = new_err & ~state.err;


        // Bus answer
        // Unmapped offsets read zero and never stall the host
        next_state.ack = bus_go;
        reg_mux        = 32'h0000_0000;
        unique case (address)
            IBEF_OFS_ERROR:  reg_mux = {16'h0000, state.err};
            IBEF_OFS_STATUS: reg_mux = {16'h0000, state.status};
            IBEF_OFS_MASK:   reg_mux = {16'h0000, state.mask};
            IBEF_OFS_CONFIG: reg_mux = {28'h0000000, state.config_bits};
            IBEF_OFS_MONTIM: reg_mux = {8'h00, state.mon_time};
            default:         reg_mux = 32'h0000_0000;
        endcase
        if (bus_go && read) begin
            next_state.rdata = reg_mux;
        end

        // Writes reach only control registers, never the error word
        if (bus_done && write) begin
            unique case (address)
                IBEF_OFS_MASK: begin
                    next_state.mask = 16'((32'(state.mask) & ~wmask)
                                          | (writedata & wmask));
                end
                IBEF_OFS_CONFIG: begin
                    next_state.config_bits = 4'(
                        (32'(state.config_bits) & ~wmask)
                        | (writedata & wmask));
                end
                IBEF_OFS_MONTIM: begin
                    next_state.mon_time = 24'(
                        (32'(state.mon_time) & ~wmask)
                        | (writedata & wmask));
                end
                default: begin
                end
            endcase
        end


        // Status clears on read; a new event in that cycle survives
        // Events after the read data was latched are not yet reported,
        // so only the bits the host has seen are taken away.
        if (rd_clear) begin
            next_state.status = (state.status & ~state.rdata[15:0]) | rise;
        end else begin
            next_state.status = state.status | rise;
        end

        next_state.irq = |(next_state.status & next_state.mask);
    end


    // Synchronous reset; the whole record takes its reset value at once
    // so no field can lag the others by a cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= IBEF_RST_STATE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs are plain wires from the state record, except waitrequest, which inverts ack
    assign readdata                     = state.rdata;
    assign waitrequest                  = !state.ack;
    assign board_error_information_word = state.err;
    assign fatal_error                  = state.fatal;
    assign irq                          = state.irq;

endmodule // ibef_error_flags

// ==== src/ibef_pkg.sv ====
// Package of the board error flag block: register map, bit positions,
// reset values and timing constants.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package ibef_pkg;

    // Register byte offsets
    localparam logic [4:0] IBEF_OFS_ERROR  = 5'h00;
    localparam logic [4:0] IBEF_OFS_STATUS = 5'h04;
    localparam logic [4:0] IBEF_OFS_MASK   = 5'h08;
    localparam logic [4:0] IBEF_OFS_CONFIG = 5'h0C;
    localparam logic [4:0] IBEF_OFS_MONTIM = 5'h10;

    // Error word bit positions
    localparam int IBEF_BIT_WDT      = 0;
    localparam int IBEF_BIT_BUS      = 1;
    localparam int IBEF_BIT_CYC_PROC = 2;
    localparam int IBEF_BIT_DATA     = 3;
    localparam int IBEF_BIT_HOST     = 4;
    localparam int IBEF_BIT_CYC_BRD  = 5;
    localparam int IBEF_BIT_LOAD     = 8;
    localparam int IBEF_BIT_OPCYC    = 9;

    // Bits 00..12 carry details; 06, 07, 10..15 stay zero here
    localparam logic [15:0] IBEF_USED_MASK = 16'h033F;

    // Config register fields
    localparam int IBEF_CFG_VARIANT_LSB = 0;
    localparam int IBEF_CFG_DUPLEX      = 2;
    localparam int IBEF_CFG_MON_EN      = 3;

    // Host variants
    typedef enum logic [1:0] {
        IBEF_VAR_BOARD,
        IBEF_VAR_PROCESS_HOST,
        IBEF_VAR_LOOP_HOST
    } ibef_variant_type;

    // Reset values
    localparam logic [15:0] IBEF_RST_MASK   = 16'h0000;
    localparam logic [3:0]  IBEF_RST_CONFIG = 4'h0;
    localparam logic [23:0] IBEF_RST_MONTIM = 24'h0F4240;

    // Load rate limit in percent and the run of cycles above it
    localparam logic [6:0] IBEF_LOAD_LIMIT_PCT = 7'h50;
    localparam logic [1:0] IBEF_LOAD_RUN       = 2'h3;

    // Host cycle above 20 percent of the minimum operation cycle:
    // host * 100 > min * 20, i.e. host * 5 > min
    localparam logic [2:0] IBEF_OPCYC_FACTOR = 3'h5;

endpackage : ibef_pkg

// ==== tb/ibef_properties.sv ====
// Checker of the board error flag block, bound to its top module.
// Sees only top-level ports; one clock domain.
`timescale 1ns/100ps
module ibef_props (
    // Watched ports
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest,
    input wire logic        watchdog_fault,
    input wire logic        bus_fault,
    input wire logic        cold_check_fail,
    input wire logic        host_unsupported,
    input wire logic        op_cycle_tick,
    input wire logic [15:0] board_error_information_word,
    input wire logic        fatal_error
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire [15:0] w = board_error_information_word;
    sequence s_req; (read || write) && waitrequest; endsequence
    sequence s_ack; !waitrequest ##1 waitrequest; endsequence
    a_bus_answer: assert property (s_req |=> s_ack)
        else $error("bus answer");
    a_wdt_latch: assert property (!reset && watchdog_fault |=> w[0])
        else $error("wdt flag");
    a_bus_latch: assert property (!reset && bus_fault |=> w[1] && fatal_error)
        else $error("bus flag");
    a_cold_latch: assert property (!reset && cold_check_fail |=> w[3])
        else $error("data flag");
    a_host_follow: assert property (!reset |=> w[4] == $past(host_unsupported))
        else $error("host flag");
    a_unused_zero: assert property (w[7:6] == 2'h0 && w[15:10] == 6'h00)
        else $error("unused bits");
    a_fatal_sum: assert property (fatal_error == |(w & 16'h002F))
        else $error("fatal sum");
    a_load_hold: assert property (!reset && !op_cycle_tick |=> $stable(w[9:8]))
        else $error("load bits moved");
endmodule // ibef_props

bind ibef_error_flags ibef_props u_props (.clock(clock), .reset(reset), .read(read),
    .write(write), .waitrequest(waitrequest), .watchdog_fault(watchdog_fault),
    .bus_fault(bus_fault), .cold_check_fail(cold_check_fail),
    .host_unsupported(host_unsupported), .op_cycle_tick(op_cycle_tick),
    .board_error_information_word(board_error_information_word), .fatal_error(fatal_error));

// ==== tb/ibef_host_model.sv ====
// Host model: Avalon-MM master reaching the flag registers.
// Assumes one clock shared with the slave.
`timescale 1ns/100ps
module ibef_host_model (
    // Bus
    input  wire logic        clock,
    output logic      [4:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    initial begin
        {address, read, write, writedata} = 39'h0;
        byteenable = 4'hF;
    end
    task automatic acc(input logic we, logic [4:0] a, logic [31:0] d,
        output logic [31:0] q, output logic to);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !we;
        write <= we;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        q = readdata;
        to = waitrequest !== 1'b0;
        {read, write} <= 2'h0;
        // Released data turns over so a stale word is never taken
        writedata <= ~d;
    endtask
endmodule // ibef_host_model

// ==== tb/tb_top.sv ====
// Bench of the board error flag block: registers, faults, interrupt,
// cyclic monitor and per-cycle load and host cycle judging.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top
    import ibef_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  address;
    logic        read, write, waitrequest, fatal_error, irq, to, tick = 1'b0;
    logic [31:0] writedata, readdata, q, lfsr = 32'hA75B;
    logic [3:0]  byteenable;
    logic [6:0]  flt = 7'h00, load = 7'h00;
    logic [15:0] hc = 16'h1, mc = 16'h1, word;
    logic [6:0]  fm [6] = '{7'h01, 7'h02, 7'h10, 7'h40, 7'h20, 7'h20};
    logic [15:0] fw [6] = '{16'h1, 16'h2, 16'h8, 16'h10, 16'h0, 16'h8};
    logic [15:0] cw [4] = '{16'h20, 16'h4, 16'h20, 16'h0};
    int          error_cnt = 0, n_compared = 0, run, ld, h, m;
    always #2.5 clock = ~clock;
    ibef_error_flags DUT (.clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .watchdog_fault(flt[0]), .bus_fault(flt[1]),
        .token_sent(flt[2]), .token_returned(flt[3]), .cold_check_fail(flt[4]),
        .all_db_fail(flt[5]), .host_unsupported(flt[6]), .op_cycle_tick(tick),
        .loop_controller_load(load), .host_cycle_time(hc), .min_op_cycle(mc),
        .board_error_information_word(word), .fatal_error(fatal_error), .irq(irq));
    ibef_host_model host (.clock(clock), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest));
    function automatic logic [31:0] step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Bit 9 strictly above a fifth, bit 8 after three high ticks
    function automatic logic [1:0] judge(input int hh, mm, r);
        return {hh * 5 > mm, r >= 3};
    endfunction
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic go(input logic we, input logic [4:0] a, input logic [31:0] d);
        host.acc(we, a, d, q, to);
        if (to) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        go(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic restart();
        flt <= 7'h00;
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
    endtask
    initial begin
        restart();
        rd(IBEF_OFS_MASK, 32'h0);
        rd(IBEF_OFS_MONTIM, 32'h000F4240);
        go(1'b1, IBEF_OFS_ERROR, 32'hFFFF);
        rd(IBEF_OFS_ERROR, 32'h0);
        rd(5'h14, 32'h0);
        for (int i = 0; i < 6; i++) begin
            restart();
            go(1'b1, IBEF_OFS_MASK, (i == 0) ? 32'h0 : 32'hFFFF);
            go(1'b1, IBEF_OFS_CONFIG, {29'h0, i == 5, 2'h0});
            flt <= fm[i];
            rd(IBEF_OFS_ERROR, {16'h0, fw[i]});
            `CHK(irq, i != 0 && i != 4)
            `CHK(fatal_error, i != 3 && i != 4)
            rd(IBEF_OFS_STATUS, {16'h0, fw[i]});
            flt <= 7'h00;
            @(posedge clock);
            `CHK(irq, 1'b0)
        end
        for (int v = 0; v < 4; v++) begin
            restart();
            go(1'b1, IBEF_OFS_MONTIM, 32'h14);
            go(1'b1, IBEF_OFS_CONFIG, 32'h8 | 32'(v % 3));
            flt <= 7'h04;
            repeat (8) @(posedge clock);
            flt <= (v == 3) ? 7'h08 : 7'h00;
            repeat (30) @(posedge clock);
            flt <= 7'h00;
            rd(IBEF_OFS_ERROR, {16'h0, cw[v]});
        end
        restart();
        go(1'b1, IBEF_OFS_CONFIG, 32'h5);
        run = 0;
        for (int k = 0; k < 80; k++) begin
            lfsr = step(lfsr);
            ld = 78 + lfsr[2:0] % 6;
            h = lfsr[6:3] + 1;
            m = h * 5 + lfsr[8:7] - 1;
            load <= 7'(ld);
            hc <= 16'(h);
            mc <= 16'(m);
            tick <= 1'b1;
            @(posedge clock);
            tick <= 1'b0;
            run = (ld > 80) ? run + 1 : 0;
            @(posedge clock);
            `CHK(word[9:8], judge(h, m, run))
        end
        test_done();
    end
endmodule // tb_top
